// ---- core/escr_top.sv ----
// Top of the exception state and reset control block with Avalon-MM slave
`timescale 1ns/1ps
// How it works
// - Writing one clears pending tick exception
// - Tick clear bit write-only, reads zero
// - Bit 22 flags any pending interrupt
// - Field reports highest pending enabled exception
// - Field reports active exception, zero thread
// - Interrupt exception number is index plus sixteen
// - Reset control writes need key 0x05FA
// - Bit 15 reports implemented byte order
// - Keyed bit 2 requests system reset
// - No non-maskable interrupt source exists
// - Writing one sets tick pending, reads state
module escr_top #(
    parameter int   NIRQ           = 32,
    parameter logic BIG_ENDIAN     = 1'b0
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic [3:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    input  wire logic            tick_event,
    input  wire logic [NIRQ-1:0] irq_lines,
    input  wire logic [5:0]      active_exception_number,
    output logic                 system_reset_request,
    output logic                 tick_pending_out
);
    escr_exc_if #(.NIRQ(NIRQ)) exc ();

    escr_pick #(.NIRQ(NIRQ)) u_pick (
        .exc (exc)
    );

    escr_pkg::escr_bus_state_e state_reg;
    logic [31:0]               readdata_reg;
    logic                      tick_pending_reg;
    logic                      tick_enable_reg;
    logic [NIRQ-1:0]           irq_enable_reg;
    logic [NIRQ-1:0]           irq_sync1_reg;
    logic [NIRQ-1:0]           irq_sync2_reg;
    logic                      tick_sync1_reg;
    logic                      tick_sync2_reg;
    logic                      tick_prev_reg;
    logic [5:0]                active_sync1_reg;
    logic [5:0]                active_sync2_reg;
    logic [2:0]                reset_cnt_reg;
    logic                      reset_req_reg;
    logic                      wr_go;
    logic                      rd_go;
    logic                      full_word;
    logic                      key_ok;
    logic                      tick_rise;

    // Write strobe for one register offset; shared by every writable field
    function automatic logic wr_hit(input logic go, input logic [3:0] adr, input logic [3:0] ofs);
        return go && (adr == ofs);
    endfunction

    // Pin inputs pass two flops before use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_sync1_reg    <= '0;
            irq_sync2_reg    <= '0;
            tick_sync1_reg   <= 1'b0;
            tick_sync2_reg   <= 1'b0;
            tick_prev_reg    <= 1'b0;
            active_sync1_reg <= escr_pkg::EXC_NONE;
            active_sync2_reg <= escr_pkg::EXC_NONE;
        end else begin
            irq_sync1_reg    <= irq_lines;
            irq_sync2_reg    <= irq_sync1_reg;
            tick_sync1_reg   <= tick_event;
            tick_sync2_reg   <= tick_sync1_reg;
            tick_prev_reg    <= tick_sync2_reg;
            active_sync1_reg <= active_exception_number;
            active_sync2_reg <= active_sync1_reg;
        end
    end

    // Decoded strobes; partial-word writes are ignored, registers are word wide
    assign full_word = (avs_byteenable == 4'hF);
    assign wr_go     = (state_reg == escr_pkg::ESCR_ACCESS) && avs_write && full_word;
    assign rd_go     = (state_reg == escr_pkg::ESCR_ACCESS) && avs_read;
    assign key_ok    = (avs_writedata[escr_pkg::POS_KEY +: 16] == escr_pkg::WRITE_KEY);
    assign tick_rise = tick_sync2_reg && !tick_prev_reg;

    // Picker inputs; no non-maskable source is ever fed in
    assign exc.irq_pending  = irq_sync2_reg;
    assign exc.irq_enable   = irq_enable_reg;
    assign exc.tick_pending = tick_pending_reg;
    assign exc.tick_enable  = tick_enable_reg;

    // Bus handshake: accept, then answer one cycle later with waitrequest low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= escr_pkg::ESCR_IDLE;
        end else begin
            case (state_reg)
                escr_pkg::ESCR_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_reg <= escr_pkg::ESCR_ACCESS;
                    end
                end
                escr_pkg::ESCR_ACCESS: begin
                    state_reg <= escr_pkg::ESCR_DONE;
                end
                escr_pkg::ESCR_DONE: begin
                    state_reg <= escr_pkg::ESCR_IDLE;
                end
                default: begin
                    state_reg <= escr_pkg::ESCR_IDLE;
                end
            endcase
        end
    end

    // Waitrequest high except in the answer cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(state_reg == escr_pkg::ESCR_ACCESS);
        end
    end

    // Tick pending: hardware set beats software clear, and set beats clear in one write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_pending_reg <= 1'b0;
        end else if (tick_rise) begin
            tick_pending_reg <= 1'b1;
        end else if (wr_hit(wr_go, avs_address, escr_pkg::OFS_INT_CTRL_STATE)) begin
            if (avs_writedata[escr_pkg::BIT_TICK_SET_PEND]) begin
                tick_pending_reg <= 1'b1;
            end else if (avs_writedata[escr_pkg::BIT_TICK_CLR_PEND]) begin
                tick_pending_reg <= 1'b0;
            end
        end
    end

    // Enables for the picker; kept at the two spare offsets, reset to all off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_enable_reg  <= '0;
            tick_enable_reg <= 1'b0;
        end else if (wr_hit(wr_go, avs_address, escr_pkg::OFS_EXC_ENABLE)) begin
            irq_enable_reg  <= avs_writedata[NIRQ-1:0];
        end else if (wr_hit(wr_go, avs_address, escr_pkg::OFS_EXC_SOURCE)) begin
            tick_enable_reg <= avs_writedata[0];
        end
    end

    // Keyed reset request, stretched so the reset controller sees it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_cnt_reg <= '0;
            reset_req_reg <= 1'b0;
        end else if (wr_hit(wr_go, avs_address, escr_pkg::OFS_APP_RESET_CTRL) && key_ok
                     && avs_writedata[escr_pkg::BIT_SYS_RESET_REQ]) begin
            reset_cnt_reg <= 3'(escr_pkg::RESET_PULSE_CYCLES);
            reset_req_reg <= 1'b1;
        end else if (reset_cnt_reg != '0) begin
            reset_cnt_reg <= reset_cnt_reg - 3'd1;
            reset_req_reg <= (reset_cnt_reg != 3'd1);
        end else begin
            reset_req_reg <= 1'b0;
        end
    end

    // Outputs from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            system_reset_request <= 1'b0;
            tick_pending_out     <= 1'b0;
        end else begin
            system_reset_request <= reset_req_reg;
            tick_pending_out     <= tick_pending_reg;
        end
    end

    // Read mux; reserved, key and write-only bits read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readdata_reg <= '0;
        end else if (rd_go) begin
            readdata_reg <= '0;
            case (avs_address)
                escr_pkg::OFS_INT_CTRL_STATE: begin
                    readdata_reg[escr_pkg::BIT_TICK_SET_PEND] <= tick_pending_reg;
                    readdata_reg[escr_pkg::BIT_TICK_CLR_PEND] <= 1'b0;
                    readdata_reg[escr_pkg::BIT_ANY_PEND]      <= exc.any_interrupt_pending;
                    readdata_reg[escr_pkg::POS_HIGH_PEND +: escr_pkg::EXC_W] <=
                        exc.highest_pending_exception;
                    readdata_reg[escr_pkg::POS_ACTIVE +: escr_pkg::EXC_W] <=
                        active_sync2_reg;
                end
                escr_pkg::OFS_APP_RESET_CTRL: begin
                    readdata_reg[escr_pkg::BIT_BYTE_ORDER] <= BIG_ENDIAN;
                end
                escr_pkg::OFS_EXC_SOURCE: begin
                    readdata_reg[0] <= tick_enable_reg;
                end
                escr_pkg::OFS_EXC_ENABLE: begin
                    readdata_reg[NIRQ-1:0] <= irq_enable_reg;
                end
                default: begin
                    readdata_reg <= '0;
                end
            endcase
        end
    end

    assign avs_readdata = readdata_reg;
endmodule

// ---- core/escr_pkg.sv ----
// Package with register map, field layout and constants of the exception state and reset control block
package escr_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0]  OFS_INT_CTRL_STATE  = 4'h0;
    localparam logic [3:0]  OFS_APP_RESET_CTRL  = 4'h4;
    localparam logic [3:0]  OFS_EXC_SOURCE      = 4'h8;
    localparam logic [3:0]  OFS_EXC_ENABLE      = 4'hC;

    // Interrupt control/state field positions
    localparam int          BIT_TICK_SET_PEND   = 26;
    localparam int          BIT_TICK_CLR_PEND   = 25;
    localparam int          BIT_ANY_PEND        = 22;
    localparam int          POS_HIGH_PEND       = 12;
    localparam int          POS_ACTIVE          = 0;

    // Reset control field positions and key
    localparam int          POS_KEY             = 16;
    localparam logic [15:0] WRITE_KEY           = 16'h05FA;
    localparam int          BIT_BYTE_ORDER      = 15;
    localparam int          BIT_SYS_RESET_REQ   = 2;

    // Exception numbering
    localparam int          EXC_W               = 6;
    localparam int          NUM_IRQ             = 32;
    localparam logic [5:0]  EXC_NONE            = 6'h00;
    localparam logic [5:0]  EXC_TICK            = 6'h0F;
    localparam logic [5:0]  EXC_IRQ_BASE        = 6'h10;

    // Reset request pulse length, in cycles
    localparam int          RESET_PULSE_CYCLES  = 4;

    // Bus slave states
    typedef enum logic [2:0] {
        ESCR_IDLE   = 3'b001,
        ESCR_ACCESS = 3'b010,
        ESCR_DONE   = 3'b100
    } escr_bus_state_e;
endpackage

// ---- core/escr_exc_if.sv ----
// Interface carrying exception state between the top and the priority picker
`timescale 1ns/1ps
interface escr_exc_if #(
    parameter int NIRQ = 32
);
    logic [NIRQ-1:0] irq_pending;
    logic [NIRQ-1:0] irq_enable;
    logic            tick_pending;
    logic            tick_enable;
    logic [5:0]      highest_pending_exception;
    logic            any_interrupt_pending;

    modport top (
        output irq_pending,
        output irq_enable,
        output tick_pending,
        output tick_enable,
        input  highest_pending_exception,
        input  any_interrupt_pending
    );
    modport picker (
        input  irq_pending,
        input  irq_enable,
        input  tick_pending,
        input  tick_enable,
        output highest_pending_exception,
        output any_interrupt_pending
    );
endinterface

// ---- core/escr_pick.sv ----
// Combinational picker of the highest-priority pending enabled exception
`timescale 1ns/1ps
module escr_pick #(
    parameter int NIRQ = 32
) (
    escr_exc_if.picker exc
);
    // Lowest exception number wins; equal priority levels assumed
    always_comb begin
        exc.highest_pending_exception = escr_pkg::EXC_NONE;
        exc.any_interrupt_pending     = |exc.irq_pending;
        for (int i = NIRQ - 1; i >= 0; i--) begin
            if (exc.irq_pending[i] && exc.irq_enable[i]) begin
                exc.highest_pending_exception = escr_pkg::EXC_IRQ_BASE + 6'(i);
            end
        end
        if (exc.tick_pending && exc.tick_enable) begin
            exc.highest_pending_exception = escr_pkg::EXC_TICK;
        end
    end
endmodule

// ---- test/escr_chk.sv ----
// Concurrent checks on the exception state and reset control ports
`timescale 1ns/1ps
module escr_chk #(
    parameter int   NIRQ       = 32,
    parameter logic BIG_ENDIAN = 1'b0
) (
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic [3:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic [3:0]      avs_byteenable,
    input wire logic [31:0]     avs_readdata,
    input wire logic            avs_waitrequest,
    input wire logic            tick_event,
    input wire logic [NIRQ-1:0] irq_lines,
    input wire logic [5:0]      active_exception_number,
    input wire logic            system_reset_request,
    input wire logic            tick_pending_out
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Answered accesses, seen at the sampling edge
    wire logic rd_ok = avs_read && !avs_waitrequest;
    wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
    wire logic ctl_wr = wr_ok && avs_address == escr_pkg::OFS_APP_RESET_CTRL;
    wire logic st_wr = wr_ok && avs_address == escr_pkg::OFS_INT_CTRL_STATE;
    sequence seq_key_wr;
        ctl_wr && avs_writedata[31:16] == escr_pkg::WRITE_KEY && avs_writedata[2];
    endsequence
    sequence seq_pulse;
        system_reset_request [*4] ##1 !system_reset_request;
    endsequence
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_answer_bound: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
        else $error("access not answered in time");
    a_key_reset: assert property (seq_key_wr |-> ##[1:2] system_reset_request)
        else $error("keyed reset write gave no request");
    a_rst_pulse: assert property ($rose(system_reset_request) |-> seq_pulse)
        else $error("reset request pulse has wrong length");
    a_no_key: assert property (ctl_wr && avs_writedata[31:16] != escr_pkg::WRITE_KEY && !system_reset_request
        |=> !system_reset_request [*3]) else $error("unkeyed write acted");
    a_state_rsvd: assert property (rd_ok && avs_address == escr_pkg::OFS_INT_CTRL_STATE |-> avs_readdata[31:27] == 5'h0
        && avs_readdata[24:23] == 2'h0 && avs_readdata[21:18] == 4'h0 && avs_readdata[11:6] == 6'h0)
        else $error("reserved state bits not zero");
    a_ctl_read: assert property (rd_ok && avs_address == escr_pkg::OFS_APP_RESET_CTRL
        |-> avs_readdata == {16'h0000, BIG_ENDIAN, 15'h0000}) else $error("reset control readback wrong");
    a_tick_set: assert property (st_wr && avs_writedata[26] |-> ##[1:2] tick_pending_out)
        else $error("tick set did not pend");
    // A tick edge still in the pin synchroniser may legally set pending again
    a_tick_clr: assert property (st_wr && avs_writedata[25] && !avs_writedata[26] && !tick_event
        && !$past(tick_event) && !$past(tick_event, 2) && !$past(tick_event, 3)
        |-> ##[1:2] !tick_pending_out) else $error("tick clear did not clear");
endmodule
bind escr_top escr_chk #(.NIRQ(NIRQ), .BIG_ENDIAN(BIG_ENDIAN)) chk_u (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tick_event(tick_event), .irq_lines(irq_lines), .active_exception_number(active_exception_number),
    .system_reset_request(system_reset_request), .tick_pending_out(tick_pending_out));

// ---- test/escr_top_test.sv ----
// Self-checking bench for the exception state and reset control block
`timescale 1ns/1ps
module escr_top_test;
    logic        clk;
    logic        resetn;
    logic [3:0]  adr;
    logic        rd_s;
    logic        wr_s;
    logic [31:0] wdat;
    logic [3:0]  be;
    logic [31:0] rdat;
    logic        wait_s;
    logic        tick_ev;
    logic [31:0] irq;
    logic [5:0]  act;
    logic        rst_req;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [4:0]  idx;
    int          err_total;
    int          num_checks;
    int          rst_seen;
    escr_top #(.NIRQ(32), .BIG_ENDIAN(1'b0)) dut_u (.clk(clk), .resetn(resetn), .avs_address(adr),
        .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_s), .tick_event(tick_ev), .irq_lines(irq), .active_exception_number(act),
        .system_reset_request(rst_req), .tick_pending_out());
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hold the request until waitrequest is seen low, then let an edge pass; the watchdog ends a hang
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        rd_s <= !we;
        wr_s <= we;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wait_s !== 1'b0) begin
            @(posedge clk);
        end
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask
    // Read data compared at the answering edge, oldest note first
    always @(posedge clk) begin
        if (rd_s && wait_s === 1'b0 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk(rdat & note[63:32], note[31:0]);
        end
    end
    always @(posedge rst_req) rst_seen++;
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial begin
        resetn = 1'b0;
        {rd_s, wr_s, tick_ev} = 3'h0;
        adr = 4'h0;
        wdat = 32'h0000_0000;
        be = 4'hF;
        irq = 32'h0000_0000;
        act = 6'h00;
        err_total = 0;
        num_checks = 0;
        rst_seen = 0;
        void'($urandom(32'hd7cc));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Quiet state; bit 25 and the key field are masked as undefined
        rd(4'h0, 32'hFDFF_FFFF, 32'h0000_0000);
        rd(4'h4, 32'h0000_FFFF, 32'h0000_0000);
        rd(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
        // Tick pending: set, write zero, clear, disabled, event
        bus(1'b1, 4'h8, 32'h0000_0001);
        bus(1'b1, 4'h0, 32'h0400_0000);
        rd(4'h0, 32'h0443_F000, 32'h0400_F000);
        bus(1'b1, 4'h0, 32'h0000_0000);
        rd(4'h0, 32'h0443_F000, 32'h0400_F000);
        bus(1'b1, 4'h0, 32'h0200_0000);
        rd(4'h0, 32'h0443_F000, 32'h0000_0000);
        bus(1'b1, 4'h8, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0400_0000);
        rd(4'h0, 32'h0443_F000, 32'h0400_0000);
        bus(1'b1, 4'h8, 32'h0000_0001);
        bus(1'b1, 4'h0, 32'h0200_0000);
        tick_ev <= 1'b1;
        repeat (4) @(posedge clk);
        tick_ev <= 1'b0;
        repeat (4) @(posedge clk);
        rd(4'h0, 32'h0443_F000, 32'h0400_F000);
        bus(1'b1, 4'h0, 32'h0200_0000);
        // Interrupts: lowest enabled index wins, number is index plus sixteen
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        rd(4'hC, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        rd(4'h8, 32'hFFFF_FFFF, 32'h0000_0001);
        for (int k = 0; k < 5; k++) begin
            idx = 5'($urandom);
            irq <= (32'h0000_0001 << idx) | 32'h8000_0000;
            repeat (4) @(posedge clk);
            rd(4'h0, 32'h0443_F000, 32'h0040_0000 | ((32'(idx) + 32'h0000_0010) << 12));
        end
        bus(1'b1, 4'h0, 32'h0400_0000);
        rd(4'h0, 32'h0443_F000, 32'h0440_F000);
        bus(1'b1, 4'h0, 32'h0200_0000);
        bus(1'b1, 4'hC, 32'h0000_0000);
        rd(4'h0, 32'h0443_F000, 32'h0040_0000);
        irq <= 32'h0000_0000;
        // Active exception number follows its input
        for (int k = 0; k < 3; k++) begin
            act <= 6'($urandom);
            repeat (4) @(posedge clk);
            rd(4'h0, 32'h0000_003F, {26'h0, act});
        end
        act <= 6'h00;
        bus(1'b1, 4'h0, 32'hF9FF_FFFF);
        rd(4'h0, 32'hFDFF_FFFF, 32'h0000_0000);
        // Reset control: no key, partial lanes, keyed without bit 2, keyed
        bus(1'b1, 4'h4, 32'h0000_0004);
        be <= 4'h7;
        bus(1'b1, 4'h4, 32'h05FA_0004);
        be <= 4'hF;
        bus(1'b1, 4'h4, 32'h05FA_FFF9);
        rd(4'h4, 32'h0000_FFFF, 32'h0000_0000);
        repeat (6) @(posedge clk);
        chk(32'(rst_seen), 32'h0000_0000);
        bus(1'b1, 4'h4, 32'h05FA_0004);
        repeat (8) @(posedge clk);
        chk(32'(rst_seen), 32'h0000_0001);
        if (exp_q.size() != 0) err_total++;
        final_report();
    end
endmodule
